/* File: cfa_can_engine.sv */
// far-side model: CAN engine stepping FIFO indices and fetching buffers from RAM
`timescale 1ns/1ps
module cfa_can_engine #(
  parameter int NFIFO = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic [4:0] sel,
  input wire logic [31:0] ram_addr,
  output logic [NFIFO-1:0] can_adv,
  output logic [31:0] fetch_addr
);
  // one pulse per request, one FIFO at a time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      can_adv <= '0;
    end else begin
      can_adv <= go ? (NFIFO'(1) << sel) : '0;
    end
  end

  // buffer address goes onto the RAM bus as given, no translation
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_addr <= 32'h0;
    end else begin
      fetch_addr <= ram_addr;
    end
  end
endmodule : cfa_can_engine

/* File: cfa_fifo_ptr.sv */
// per-FIFO user-side and CAN-side message indices
`timescale 1ns/1ps
module cfa_fifo_ptr #(
  parameter int N = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  cfa_ptr_if.ptr p
);
  import cfa_pkg::*;

  // ---------------------------------------------------------------
  // index advance with wrap at the FIFO depth
  // ---------------------------------------------------------------
  function automatic logic [4:0] cfa_step(input logic [4:0] idx, input logic [4:0] last);
    return (idx == last) ? 5'h00 : idx + 5'h01;
  endfunction : cfa_step

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        p.user_idx[i] <= 5'h00;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (p.clr) begin
          p.user_idx[i] <= 5'h00;
        end else if (p.user_inc[i]) begin
          p.user_idx[i] <= cfa_step(p.user_idx[i], p.depth_m1[i]);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        p.can_idx[i] <= 5'h00;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        if (p.clr) begin
          p.can_idx[i] <= 5'h00;
        end else if (p.can_inc[i]) begin
          p.can_idx[i] <= cfa_step(p.can_idx[i], p.depth_m1[i]);
        end
      end
    end
  end

endmodule : cfa_fifo_ptr

/* File: cfa_layout.sv */
// start word of each FIFO, packed one after another from the base
`timescale 1ns/1ps
module cfa_layout #(
  parameter int N = 32
) (
  cfa_ptr_if.lay l
);
  import cfa_pkg::*;

  always_comb begin
    cfa_word_t acc;
    acc = CFA_ZERO;
    for (int i = 0; i < N; i++) begin
      l.start_word[i] = acc;
      acc = acc + (32'(l.depth_m1[i]) + CFA_ONE) * (32'(l.words_m1[i]) + CFA_ONE);
    end
  end

endmodule : cfa_layout

/* File: cfa_pkg.sv */
// constants, types and address helper for the CAN message FIFO addressing block
package cfa_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int CFA_NFIFO = 32;
  localparam int CFA_IDX_W = 5;
  localparam int CFA_WORDS_W = 4;
  localparam int CFA_ADDR_W = 12;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] CFA_OFF_CTRL = 12'h000;
  localparam logic [11:0] CFA_OFF_BASE = 12'h004;
  localparam logic [2:0] CFA_FIFO_REGION = 3'h1;
  localparam int CFA_REGION_LSB = 9;
  localparam int CFA_FIFO_SEL_LSB = 4;
  localparam logic [3:0] CFA_SUB_CFG = 4'h0;
  localparam logic [3:0] CFA_SUB_UA = 4'h4;
  localparam logic [3:0] CFA_SUB_CI = 4'h8;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int CFA_OPERATION_MODE_FIELD_LSB = 21;
  localparam int CFA_OPERATION_MODE_FIELD_MSB = 23;
  localparam logic [2:0] CFA_OPERATION_MODE_FIELD_CONFIG = 3'h4;
  localparam logic [2:0] CFA_OPERATION_MODE_FIELD_RESET = 3'h4;
  localparam int CFA_CFG_TX_BIT = 0;
  localparam int CFA_CFG_DEPTH_LSB = 8;
  localparam int CFA_CFG_DEPTH_MSB = 12;
  localparam int CFA_CFG_WORDS_LSB = 16;
  localparam int CFA_CFG_WORDS_MSB = 19;
  localparam int CFA_CFG_UINC_BIT = 24;
  localparam logic [31:0] CFA_BASE_MASK = 32'hffff_fffc;
  localparam logic [31:0] CFA_BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] CFA_ZERO = 32'h0000_0000;
  localparam logic [31:0] CFA_ONE = 32'h0000_0001;
  localparam int CFA_WORD_SHIFT = 2;

  typedef logic [31:0] cfa_word_t;

  // physical RAM address of message idx in a FIFO starting at start_word
  function automatic cfa_word_t cfa_msg_addr(input cfa_word_t base, input cfa_word_t start,
                                             input logic [4:0] idx, input logic [3:0] words_m1);
    cfa_word_t w;
    w = start + 32'(idx) * (32'(words_m1) + CFA_ONE);
    return base + (w << CFA_WORD_SHIFT);
  endfunction : cfa_msg_addr

endpackage : cfa_pkg

/* File: cfa_ptr_if.sv */
// interface joining the control logic, the FIFO pointers and the buffer layout
`timescale 1ns/1ps
interface cfa_ptr_if #(parameter int N = 32);
  logic clr;
  logic [N-1:0] user_inc;
  logic [N-1:0] can_inc;
  logic [4:0] depth_m1 [N];
  logic [3:0] words_m1 [N];
  logic [4:0] user_idx [N];
  logic [4:0] can_idx [N];
  logic [31:0] start_word [N];

  modport ctrl (output clr, output user_inc, output can_inc, output depth_m1,
                output words_m1, input user_idx, input can_idx, input start_word);
  modport ptr (input clr, input user_inc, input can_inc, input depth_m1,
               output user_idx, output can_idx);
  modport lay (input depth_m1, input words_m1, output start_word);
endinterface : cfa_ptr_if

/* File: cfa_top.sv */
// CAN message buffer addressing: base pointer, FIFO layout, user and CAN indices
`timescale 1ns/1ps
module cfa_top #(
  parameter int NFIFO = cfa_pkg::CFA_NFIFO
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [cfa_pkg::CFA_ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [NFIFO-1:0] CAN_ADV,
  input wire logic [4:0] CAN_SEL,
  output logic [31:0] CAN_RAM_ADDR,
  output logic [2:0] OP_MODE
);
  import cfa_pkg::*;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cfa_ptr_if #(.N(NFIFO)) pi ();
  logic [2:0] operation_mode_field_reg;
  cfa_word_t base_reg;
  logic [NFIFO-1:0] tx_reg;
  logic [4:0] depth_reg [NFIFO];
  logic [3:0] words_reg [NFIFO];
  cfa_word_t rdata_reg;
  cfa_word_t rdata_next;
  cfa_word_t can_addr_reg;
  logic cfg_mode;
  logic in_fifo;
  logic [4:0] fsel;
  logic [3:0] sub;
  logic hit_cfg;
  logic hit_ua;
  logic hit_ci;
  cfa_word_t ua_value;
  cfa_word_t can_value;

  assign cfg_mode = (operation_mode_field_reg == CFA_OPERATION_MODE_FIELD_CONFIG);
  assign in_fifo = (ADDR[CFA_ADDR_W-1:CFA_REGION_LSB] == CFA_FIFO_REGION);
  assign fsel = ADDR[CFA_FIFO_SEL_LSB +: CFA_IDX_W];
  assign sub = ADDR[3:0];
  assign hit_cfg = in_fifo && (sub == CFA_SUB_CFG) && (32'(fsel) < NFIFO);
  assign hit_ua = in_fifo && (sub == CFA_SUB_UA) && (32'(fsel) < NFIFO);
  assign hit_ci = in_fifo && (sub == CFA_SUB_CI) && (32'(fsel) < NFIFO);

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  cfa_fifo_ptr #(.N(NFIFO)) u_ptr (
    .clk(CLK),
    .rst_n(rst_n),
    .p(pi.ptr)
  );

  cfa_layout #(.N(NFIFO)) u_lay (
    .l(pi.lay)
  );

  always_comb begin
    for (int i = 0; i < NFIFO; i++) begin
      pi.depth_m1[i] = depth_reg[i];
      pi.words_m1[i] = words_reg[i];
    end
  end

  // indices restart whenever the module sits in Configuration mode
  assign pi.clr = cfg_mode;

  always_comb begin
    pi.user_inc = '0;
    if (WR && hit_cfg && WDATA[CFA_CFG_UINC_BIT] && !cfg_mode) begin
      pi.user_inc[fsel] = 1'b1;
    end
  end
  assign pi.can_inc = cfg_mode ? '0 : CAN_ADV;

  // ---------------------------------------------------------------
  // control and base pointer
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      operation_mode_field_reg <= CFA_OPERATION_MODE_FIELD_RESET;
    end else if (WR && ADDR == CFA_OFF_CTRL) begin
      operation_mode_field_reg <= WDATA[CFA_OPERATION_MODE_FIELD_MSB:CFA_OPERATION_MODE_FIELD_LSB];
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      base_reg <= CFA_BASE_RESET;
    end else if (WR && ADDR == CFA_OFF_BASE && cfg_mode) begin
      base_reg <= WDATA & CFA_BASE_MASK;
    end
  end

  // ---------------------------------------------------------------
  // per-FIFO configuration, locked outside Configuration mode
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= '0;
      for (int i = 0; i < NFIFO; i++) begin
        depth_reg[i] <= 5'h00;
        words_reg[i] <= 4'h0;
      end
    end else if (WR && hit_cfg && cfg_mode) begin
      tx_reg[fsel] <= WDATA[CFA_CFG_TX_BIT];
      depth_reg[fsel] <= WDATA[CFA_CFG_DEPTH_MSB:CFA_CFG_DEPTH_LSB];
      words_reg[fsel] <= WDATA[CFA_CFG_WORDS_MSB:CFA_CFG_WORDS_LSB];
    end
  end

  // ---------------------------------------------------------------
  // addresses
  // ---------------------------------------------------------------
  // user side: head for transmit, tail for receive; both are the software pointer
  assign ua_value = cfa_msg_addr(base_reg, pi.start_word[fsel], pi.user_idx[fsel],
                                 words_reg[fsel]);
  assign can_value = cfa_msg_addr(base_reg, pi.start_word[CAN_SEL], pi.can_idx[CAN_SEL],
                                  words_reg[CAN_SEL]);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      can_addr_reg <= CFA_ZERO;
    end else begin
      can_addr_reg <= can_value;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = CFA_ZERO;
    if (RD) begin
      if (ADDR == CFA_OFF_CTRL) begin
        rdata_next[CFA_OPERATION_MODE_FIELD_MSB:CFA_OPERATION_MODE_FIELD_LSB] = operation_mode_field_reg;
      end else if (ADDR == CFA_OFF_BASE) begin
        rdata_next = base_reg;
      end else if (hit_cfg) begin
        rdata_next[CFA_CFG_TX_BIT] = tx_reg[fsel];
        rdata_next[CFA_CFG_DEPTH_MSB:CFA_CFG_DEPTH_LSB] = depth_reg[fsel];
        rdata_next[CFA_CFG_WORDS_MSB:CFA_CFG_WORDS_LSB] = words_reg[fsel];
      end else if (hit_ua) begin
        rdata_next = ua_value;
      end else if (hit_ci) begin
        rdata_next[CFA_IDX_W-1:0] = pi.can_idx[fsel];
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= CFA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;
  assign CAN_RAM_ADDR = can_addr_reg;
  assign OP_MODE = operation_mode_field_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  AST_BASE_ALIGN: assert property (base_reg[1:0] == 2'h0)
    else $error("base pointer low bits not zero");
  AST_BASE_WRITE: assert property (WR && ADDR == CFA_OFF_BASE && cfg_mode
    |=> base_reg == ($past(WDATA) & CFA_BASE_MASK))
    else $error("base pointer did not take the write");
  AST_BASE_LOCK: assert property (!cfg_mode |=> $stable(base_reg))
    else $error("base pointer changed outside configuration mode");
  AST_LAYOUT: assert property (NFIFO < 2 || pi.start_word[1] == pi.start_word[0]
    + (32'(depth_reg[0]) + CFA_ONE) * (32'(words_reg[0]) + CFA_ONE))
    else $error("second buffer not placed after the first");
  AST_UA_TX: assert property (RD && hit_ua && tx_reg[fsel]
    |=> RDATA == $past(ua_value) && RDATA[1:0] == 2'h0)
    else $error("transmit user address read wrong");
  AST_UA_RX: assert property (RD && hit_ua && !tx_reg[fsel] && !cfg_mode
    |=> RDATA == $past(base_reg) + ($past(32'(pi.start_word[fsel])) << 2)
        + ($past(32'(pi.user_idx[fsel]) * (32'(words_reg[fsel]) + CFA_ONE)) << 2))
    else $error("receive user address read wrong");
  AST_CI_READ: assert property (RD && hit_ci
    |=> RDATA[31:CFA_IDX_W] == '0 && RDATA[CFA_IDX_W-1:0] == $past(pi.can_idx[fsel]))
    else $error("message index read wrong");
  AST_CI_ADV: assert property (!cfg_mode && CAN_ADV[0] && pi.can_idx[0] != depth_reg[0]
    |=> pi.can_idx[0] == $past(pi.can_idx[0]) + 5'h01)
    else $error("message index did not advance");
  AST_IDX_HOLD: assert property (!pi.user_inc[0] && !pi.clr
    |=> $stable(pi.user_idx[0]))
    else $error("user index moved without advance");
  AST_CAN_ADDR: assert property (1'b1 |=> CAN_RAM_ADDR == $past(can_value))
    else $error("CAN RAM address not registered from layout");

  // ---------------------------------------------------------------
  // index, layout, mode and read-back checks
  // ---------------------------------------------------------------
  AST_RD_BASE: assert property (RD && ADDR == CFA_OFF_BASE
    |=> RDATA == $past(base_reg))
    else $error("base pointer read wrong");

  AST_RD_BASE_LOW: assert property (RD && ADDR == CFA_OFF_BASE
    |=> RDATA[1:0] == 2'h0)
    else $error("base pointer read low bits not zero");

  AST_UA_ALIGN: assert property (RD && hit_ua
    |=> RDATA[1:0] == 2'h0)
    else $error("user address not word aligned");

  AST_RD_CTRL: assert property (RD && ADDR == CFA_OFF_CTRL
    |=> RDATA[CFA_OPERATION_MODE_FIELD_MSB:CFA_OPERATION_MODE_FIELD_LSB] == $past(operation_mode_field_reg))
    else $error("operating mode read wrong");

  AST_OPERATION_MODE_FIELD_HOLD: assert property (!(WR && ADDR == CFA_OFF_CTRL)
    |=> $stable(operation_mode_field_reg))
    else $error("operating mode changed without a write");

  AST_START0: assert property (pi.start_word[0] == CFA_ZERO)
    else $error("first buffer not at the base");

  AST_LAYOUT_2: assert property (NFIFO < 3 || pi.start_word[2] == pi.start_word[1]
    + (32'(depth_reg[1]) + CFA_ONE) * (32'(words_reg[1]) + CFA_ONE))
    else $error("third buffer not placed after the second");

  AST_CI_CLR: assert property (cfg_mode
    |=> pi.can_idx[0] == 5'h00)
    else $error("message index not cleared in configuration mode");

  AST_UI_CLR: assert property (cfg_mode
    |=> pi.user_idx[0] == 5'h00)
    else $error("user index not cleared in configuration mode");

  AST_CI_WRAP: assert property (!cfg_mode && CAN_ADV[0] && pi.can_idx[0] == depth_reg[0]
    |=> pi.can_idx[0] == 5'h00)
    else $error("message index did not wrap");

  AST_CI_HOLD: assert property (!CAN_ADV[0] && !pi.clr
    |=> $stable(pi.can_idx[0]))
    else $error("message index moved without advance");

  AST_UI_ADV: assert property (!cfg_mode && WR && hit_cfg && fsel == 5'h00
    && WDATA[CFA_CFG_UINC_BIT] && pi.user_idx[0] != depth_reg[0]
    |=> pi.user_idx[0] == $past(pi.user_idx[0]) + 5'h01)
    else $error("user index did not advance");

  COV_BASE_WRITE: cover property (WR && ADDR == CFA_OFF_BASE && cfg_mode);
  COV_UA_TX_READ: cover property (RD && hit_ua && tx_reg[fsel] && !cfg_mode);
  COV_USER_WRAP: cover property (pi.user_inc[0] && pi.user_idx[0] == depth_reg[0]);
  COV_CI_READ: cover property (RD && hit_ci && pi.can_idx[fsel] != 5'h00);
  COV_CAN_WRAP: cover property (!cfg_mode && CAN_ADV[1] && pi.can_idx[1] == depth_reg[1]);

endmodule : cfa_top

/* File: cfa_top_tb.sv */
// self-checking bench for the CAN message FIFO addressing block
`timescale 1ns/1ps
module cfa_top_tb;
  import cfa_pkg::*;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [11:0] ADDR = 12'h000;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic [31:0] CAN_RAM_ADDR;
  logic [31:0] CAN_ADV;
  logic [31:0] fetch_addr;
  logic [4:0] CAN_SEL = 5'h0;
  logic [2:0] OP_MODE;
  logic go = 1'b0;
  logic [4:0] go_sel = 5'h0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'h0bedde8d;
  int nadv;
  logic [31:0] base;
  logic [31:0] rd_v;
  logic [31:0] st1;
  logic [4:0] dm [2];
  logic [3:0] wm [2];

  always #4 CLK = ~CLK;

  cfa_top #(.NFIFO(32)) u_dut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CAN_ADV(CAN_ADV), .CAN_SEL(CAN_SEL),
    .CAN_RAM_ADDR(CAN_RAM_ADDR), .OP_MODE(OP_MODE));

  cfa_can_engine #(.NFIFO(32)) u_eng (.clk(CLK), .arst_n(ARST_N), .go(go), .sel(go_sel),
    .ram_addr(CAN_RAM_ADDR), .can_adv(CAN_ADV), .fetch_addr(fetch_addr));

  // ---------------------------------------------------------------
  // expectations, bus cycles and comparison
  // ---------------------------------------------------------------
  function automatic logic [31:0] exp_addr(input logic [31:0] b, input logic [31:0] st,
                                           input logic [4:0] i, input logic [3:0] w);
    return b + ((st + 32'(i) * (32'(w) + 32'h1)) << 2);
  endfunction : exp_addr

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 rd_v = RDATA;
  endtask : rd

  task automatic adv(input logic [4:0] f);
    @(posedge CLK);
    go <= 1'b1;
    go_sel <= f;
    @(posedge CLK);
    go <= 1'b0;
  endtask : adv

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic conclude;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (5000) @(posedge CLK);
    n_mismatch++;
    conclude();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("op_mode", {29'h0, CFA_OPERATION_MODE_FIELD_CONFIG}, {29'h0, OP_MODE});
    rd(CFA_OFF_BASE);
    chk("base_reset", CFA_BASE_RESET, rd_v);
    rd(12'h208);
    chk("index_reset", 32'h0, rd_v);
    rd(12'h100);
    chk("unmapped", 32'h0, rd_v);
    base = $random(seed);
    wr(CFA_OFF_BASE, base);
    base = base & 32'hffff_fffc;
    rd(CFA_OFF_BASE);
    chk("base", base, rd_v);
    for (int f = 0; f < 2; f++) begin
      dm[f] = 5'(2 + ($random(seed) & 7));
      wm[f] = 4'($random(seed));
      wr(12'h200 + 12'(16 * f), {12'h0, wm[f], 3'h0, dm[f], 7'h0, f == 0});
    end
    st1 = (32'(dm[0]) + 32'h1) * (32'(wm[0]) + 32'h1);
    wr(CFA_OFF_CTRL, 32'h0);
    rd(CFA_OFF_CTRL);
    chk("ctrl_mode", 32'h0, rd_v & 32'h00e0_0000);
    chk("op_mode_run", 32'h0, {29'h0, OP_MODE});
    wr(CFA_OFF_BASE, ~base);
    rd(CFA_OFF_BASE);
    chk("base_locked", base, rd_v);
    rd(12'h214);
    chk("ua_rx", exp_addr(base, st1, 5'h0, wm[1]), rd_v);
    wr(12'h200, 32'h0100_0000);
    rd(12'h204);
    chk("ua_tx", exp_addr(base, 32'h0, 5'h1, wm[0]), rd_v);
    wr(12'h204, $random(seed));
    wr(12'h208, $random(seed));
    rd(12'h204);
    chk("ua_ro", exp_addr(base, 32'h0, 5'h1, wm[0]), rd_v);
    rd(12'h208);
    chk("ci_ro", 32'h0, rd_v);
    @(posedge CLK);
    CAN_SEL <= 5'h1;
    adv(5'h1);
    adv(5'h1);
    adv(5'h0);
    repeat (6) @(posedge CLK);
    #1 chk("ram_addr", exp_addr(base, st1, 5'h2, wm[1]), fetch_addr);
    rd(12'h218);
    chk("ci_rx", 32'h2, rd_v);
    rd(12'h208);
    chk("ci_tx", 32'h1, rd_v);
    @(posedge CLK);
    #1 chk("rdata_idle", 32'h0, RDATA);
    nadv = $random(seed) & 15;
    for (int k = 0; k < nadv; k++) begin
      adv(5'h1);
    end
    rd(12'h218);
    chk("ci_wrap", 32'((2 + nadv) % (int'(dm[1]) + 1)), rd_v);
    wr(CFA_OFF_CTRL, 32'h0080_0000);
    wr(CFA_OFF_BASE, 32'h0000_1003);
    rd(CFA_OFF_BASE);
    chk("base_reprog", 32'h0000_1000, rd_v);
    conclude();
  end
endmodule : cfa_top_tb
